// [core/ccd_core.sv]
/*
 * Execution unit for subroutine jumps, watchdog kick, complement, clear and
 * decrement instructions, with an AXI4-Lite register slave.
 * Assumes a decoder upstream that fetches at PC_O and supplies the file
 * operand, and a file, return stack and watchdog that take one-clock strobes.
 */
`timescale 1ns/10ps

module ccd_core
#(
    parameter int unsigned CYC_CLKS = ccd_pkg::INS_CYC_CLKS
)
(
    // clock and reset
    input  wire logic               REF_CLK_I,
    input  wire logic               RST_N_I,
    // instruction feed
    input  wire logic               INS_VALID_I,
    input  wire ccd_pkg::ccd_ins_s  INS_I,
    output      logic               INS_READY_O,
    output      logic [14:0]        PC_O,
    // file register write
    output      ccd_pkg::ccd_fwr_s  FILE_WR_O,
    // return stack
    output      ccd_pkg::ccd_push_s STACK_O,
    // watchdog
    output      logic               WDT_CLR_O,
    output      logic               WDT_PRE_CLR_O,
    // AXI4-Lite write
    input  wire logic               S_AXI_AWVALID,
    output      logic               S_AXI_AWREADY,
    input  wire logic [7:0]         S_AXI_AWADDR,
    input  wire logic               S_AXI_WVALID,
    output      logic               S_AXI_WREADY,
    input  wire logic [31:0]        S_AXI_WDATA,
    input  wire logic [3:0]         S_AXI_WSTRB,
    output      logic               S_AXI_BVALID,
    input  wire logic               S_AXI_BREADY,
    output      logic [1:0]         S_AXI_BRESP,
    // AXI4-Lite read
    input  wire logic               S_AXI_ARVALID,
    output      logic               S_AXI_ARREADY,
    input  wire logic [7:0]         S_AXI_ARADDR,
    output      logic               S_AXI_RVALID,
    input  wire logic               S_AXI_RREADY,
    output      logic [31:0]        S_AXI_RDATA,
    output      logic [1:0]         S_AXI_RRESP
);

    // =====================================================================
    // state
    typedef struct packed {
        logic [7:0]          div;
        ccd_pkg::ccd_state_e st;
        logic                skip;      // second cycle consumes next word
        logic                run;
        logic [6:0]          uplat;
        logic [7:0]          acc;
        logic                nul;
        logic                exp_n;
        logic                slp_n;
        logic [14:0]         pc;
        ccd_pkg::ccd_fwr_s   fwr;
        ccd_pkg::ccd_push_s  push;
        logic                wdt_clr;
        logic                pre_clr;
        logic                aw_got;
        logic [7:0]          aw_addr;
        logic                w_got;
        logic [31:0]         w_data;
        logic                w_lane0;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
    } ccd_state_s;

    ccd_state_s s_r;
    ccd_state_s s_nxt;

    // =====================================================================
    // address decode, shared by read and write paths
    function automatic logic ccd_mapped(input logic [7:0] a);
        ccd_mapped = (a == ccd_pkg::ADDR_CTRL)  || (a == ccd_pkg::ADDR_UPLAT)
                  || (a == ccd_pkg::ADDR_ACC)   || (a == ccd_pkg::ADDR_STATUS)
                  || (a == ccd_pkg::ADDR_PC);
    endfunction

    function automatic logic ccd_is_zero(input logic [7:0] v);
        ccd_is_zero = (v == ccd_pkg::ZERO_BYTE);
    endfunction

    logic       tick;
    logic       take;
    logic [7:0] res;
    logic [14:0] pc_inc;

    // instruction cycle enable and feed handshake
    assign tick        = (s_r.div == 8'(CYC_CLKS - 1));
    assign INS_READY_O = tick && s_r.run
                      && ((s_r.st == ccd_pkg::ST_RUN) || s_r.skip);
    assign take        = INS_READY_O && INS_VALID_I;
    assign pc_inc      = s_r.pc + 15'h0001;

    // =====================================================================
    // next state
    always_comb
    begin
        s_nxt = s_r;
        res   = ccd_pkg::ZERO_BYTE;
        s_nxt.div = tick ? 8'h00 : s_r.div + 8'h01;
        // strobes last one clock
        s_nxt.fwr.we    = 1'b0;
        s_nxt.push.push = 1'b0;
        s_nxt.wdt_clr   = 1'b0;
        s_nxt.pre_clr   = 1'b0;

        // ---- bus write: address and data taken in either order
        if (S_AXI_AWVALID && S_AXI_AWREADY)
        begin
            s_nxt.aw_got  = 1'b1;
            s_nxt.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY)
        begin
            s_nxt.w_got   = 1'b1;
            s_nxt.w_data  = S_AXI_WDATA;
            s_nxt.w_lane0 = S_AXI_WSTRB[0];
        end
        if (s_r.aw_got && s_r.w_got)
        begin
            // every field but the 15-bit PC sits in byte lane 0; only that strobe counts
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = ccd_mapped(s_r.aw_addr) ? ccd_pkg::RESP_OKAY
                                                   : ccd_pkg::RESP_SLVERR;
            if (s_r.w_lane0)
            begin
                case (s_r.aw_addr)
                    ccd_pkg::ADDR_CTRL:
                        s_nxt.run = s_r.w_data[ccd_pkg::CTRL_RUN_BIT];
                    ccd_pkg::ADDR_UPLAT:
                        s_nxt.uplat = s_r.w_data[6:0];
                    ccd_pkg::ADDR_ACC:
                        s_nxt.acc = s_r.w_data[7:0];
                    ccd_pkg::ADDR_STATUS:
                    begin
                        s_nxt.nul   = s_r.w_data[ccd_pkg::STAT_NULL_BIT];
                        s_nxt.exp_n = s_r.w_data[ccd_pkg::STAT_EXP_BIT];
                        s_nxt.slp_n = s_r.w_data[ccd_pkg::STAT_SLP_BIT];
                    end
                    ccd_pkg::ADDR_PC:
                        s_nxt.pc = s_r.w_data[14:0];
                    default:
                        s_nxt.run = s_r.run;
                endcase
            end
        end
        if (s_r.bvalid && S_AXI_BREADY)
            s_nxt.bvalid = 1'b0;

        // ---- bus read
        if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = ccd_mapped(S_AXI_ARADDR) ? ccd_pkg::RESP_OKAY
                                                    : ccd_pkg::RESP_SLVERR;
            case (S_AXI_ARADDR)
                ccd_pkg::ADDR_CTRL:   s_nxt.rdata = {31'h0, s_r.run};
                ccd_pkg::ADDR_UPLAT:  s_nxt.rdata = {25'h0, s_r.uplat};
                ccd_pkg::ADDR_ACC:    s_nxt.rdata = {24'h0, s_r.acc};
                ccd_pkg::ADDR_STATUS:
                    s_nxt.rdata = {29'h0, s_r.slp_n, s_r.exp_n, s_r.nul};
                ccd_pkg::ADDR_PC:     s_nxt.rdata = {17'h0, s_r.pc};
                default:              s_nxt.rdata = 32'h0;
            endcase
        end
        else if (s_r.rvalid && S_AXI_RREADY)
            s_nxt.rvalid = 1'b0;

        // ---- execution; overrides a bus write landing in the same clock
        if (tick && s_r.run)
        begin
            case (s_r.st)
                ccd_pkg::ST_RUN:
                begin
                    if (take)
                    begin
                        s_nxt.pc = pc_inc;
                        case (INS_I.op)
                            ccd_pkg::OP_CALL_IMM:
                            begin
                                s_nxt.push.push = 1'b1;
                                s_nxt.push.addr = pc_inc;
                                s_nxt.pc = {s_r.uplat[6:3], INS_I.imm};
                                s_nxt.st   = ccd_pkg::ST_NOP;
                                s_nxt.skip = 1'b0;
                            end
                            ccd_pkg::OP_CALL_ACC:
                            begin
                                s_nxt.push.push = 1'b1;
                                s_nxt.push.addr = pc_inc;
                                s_nxt.pc = {s_r.uplat, s_r.acc};
                                s_nxt.st   = ccd_pkg::ST_NOP;
                                s_nxt.skip = 1'b0;
                            end
                            ccd_pkg::OP_KICK:
                            begin
                                s_nxt.wdt_clr = 1'b1;
                                s_nxt.exp_n   = 1'b1;
                                s_nxt.slp_n   = 1'b1;
                                s_nxt.pre_clr = 1'b1;
                            end
                            ccd_pkg::OP_INVERT:
                            begin
                                res = ~INS_I.fval;
                                s_nxt.nul = ccd_is_zero(res);
                            end
                            ccd_pkg::OP_ZERO_F:
                            begin
                                s_nxt.fwr.we   = 1'b1;
                                s_nxt.fwr.addr = INS_I.freg;
                                s_nxt.fwr.data = ccd_pkg::ZERO_BYTE;
                                s_nxt.nul      = 1'b1;
                            end
                            ccd_pkg::OP_MINUS1:
                            begin
                                res = INS_I.fval - 8'h01;
                                s_nxt.nul = ccd_is_zero(res);
                            end
                            ccd_pkg::OP_ZERO_ACC:
                            begin
                                s_nxt.acc = ccd_pkg::ZERO_BYTE;
                                s_nxt.nul = 1'b1;
                            end
                            ccd_pkg::OP_MINUS1_SZ:
                            begin
                                res = INS_I.fval - 8'h01;
                                if (ccd_is_zero(res))
                                begin
                                    s_nxt.st   = ccd_pkg::ST_NOP;
                                    s_nxt.skip = 1'b1;
                                end
                            end
                            default:
                                s_nxt.pc = pc_inc;
                        endcase
                        // result routing for the single-operand group
                        if ((INS_I.op == ccd_pkg::OP_INVERT)
                         || (INS_I.op == ccd_pkg::OP_MINUS1)
                         || (INS_I.op == ccd_pkg::OP_MINUS1_SZ))
                        begin
                            if (INS_I.dest)
                            begin
                                s_nxt.fwr.we   = 1'b1;
                                s_nxt.fwr.addr = INS_I.freg;
                                s_nxt.fwr.data = res;
                            end
                            else
                                s_nxt.acc = res;
                        end
                    end
                end
                ccd_pkg::ST_NOP:
                begin
                    // a skip waits until a word is offered so that the next
                    // word is the one dropped; a jump's dead cycle consumes
                    // nothing so the feed refetches at PC_O
                    if (take)
                        s_nxt.pc = pc_inc;
                    if (take || !s_r.skip)
                    begin
                        s_nxt.st   = ccd_pkg::ST_RUN;
                        s_nxt.skip = 1'b0;
                    end
                end
                default:
                begin
                    s_nxt.st   = ccd_pkg::ST_RUN;
                    s_nxt.skip = 1'b0;
                end
            endcase
        end
    end

    // =====================================================================
    // state register
    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            s_r         <= '0;
            s_r.st      <= ccd_pkg::ST_RUN;
            s_r.run     <= ccd_pkg::RUN_RST;
            s_r.uplat   <= ccd_pkg::UPLAT_RST;
            s_r.acc     <= ccd_pkg::ACC_RST;
            s_r.nul     <= ccd_pkg::STAT_RST[ccd_pkg::STAT_NULL_BIT];
            s_r.exp_n   <= ccd_pkg::STAT_RST[ccd_pkg::STAT_EXP_BIT];
            s_r.slp_n   <= ccd_pkg::STAT_RST[ccd_pkg::STAT_SLP_BIT];
            s_r.pc      <= ccd_pkg::PC_RST;
        end
        else
            s_r <= s_nxt;
    end

    // =====================================================================
    // outputs, all from flops except the handshakes
    assign PC_O          = s_r.pc;
    assign FILE_WR_O     = s_r.fwr;
    assign STACK_O       = s_r.push;
    assign WDT_CLR_O     = s_r.wdt_clr;
    assign WDT_PRE_CLR_O = s_r.pre_clr;
    assign S_AXI_AWREADY = !s_r.aw_got && !s_r.bvalid;
    assign S_AXI_WREADY  = !s_r.w_got && !s_r.bvalid;
    assign S_AXI_BVALID  = s_r.bvalid;
    assign S_AXI_BRESP   = s_r.bresp;
    assign S_AXI_ARREADY = !s_r.rvalid;
    assign S_AXI_RVALID  = s_r.rvalid;
    assign S_AXI_RDATA   = s_r.rdata;
    assign S_AXI_RRESP   = s_r.rresp;

endmodule

// [core/ccd_pkg.sv]
/*
 * Constants, types and register map of the call/clear/decrement execution
 * unit. Assumes one 40 MHz clock and an AXI4-Lite master with 32-bit data.
 */
package ccd_pkg;

    // =====================================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned INS_CYC_NS    = 100;
    localparam int unsigned INS_CYC_CLKS  = INS_CYC_NS / CLK_PERIOD_NS;

    // =====================================================================
    // register map, byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_UPLAT  = 8'h04;
    localparam logic [7:0] ADDR_ACC    = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_PC     = 8'h10;

    // field positions
    localparam int unsigned CTRL_RUN_BIT  = 0;
    localparam int unsigned STAT_NULL_BIT = 0;
    localparam int unsigned STAT_EXP_BIT  = 1;
    localparam int unsigned STAT_SLP_BIT  = 2;

    // reset values
    localparam logic       RUN_RST   = 1'b0;
    localparam logic [6:0] UPLAT_RST = 7'h00;
    localparam logic [7:0] ACC_RST   = 8'h00;
    localparam logic [2:0] STAT_RST  = 3'h6;
    localparam logic [14:0] PC_RST   = 15'h0000;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // =====================================================================
    // operations handled by this unit
    typedef enum logic [3:0] {
        OP_NOP       = 4'h0,
        OP_CALL_IMM  = 4'h1,  // immediate_subroutine_jump
        OP_CALL_ACC  = 4'h2,  // indirect_subroutine_jump
        OP_KICK      = 4'h3,  // watchdog_kick
        OP_INVERT    = 4'h4,  // invert_file_reg
        OP_ZERO_F    = 4'h5,  // zero_file_reg
        OP_MINUS1    = 4'h6,  // file_reg_minus_one
        OP_ZERO_ACC  = 4'h7,  // zero_accumulator
        OP_MINUS1_SZ = 4'h8   // minus_one_skip_zero
    } ccd_op_e;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_NOP = 2'b10
    } ccd_state_e;

    // decoded instruction with its file operand already fetched
    typedef struct packed {
        ccd_op_e     op;
        logic [10:0] imm;
        logic [6:0]  freg;
        logic        dest;
        logic [7:0]  fval;
    } ccd_ins_s;

    // file register write strobe with its data
    typedef struct packed {
        logic       we;
        logic [6:0] addr;
        logic [7:0] data;
    } ccd_fwr_s;

    // return stack push strobe with its data
    typedef struct packed {
        logic        push;
        logic [14:0] addr;
    } ccd_push_s;

endpackage

// [verif/ccd_core_asserts.sv]
/*
 * Checker for the call/clear/decrement execution unit ports.
 * Assumes it is bound into ccd_core and that one clock drives everything.
 */
`timescale 1ns/10ps

module ccd_core_asserts
#(
    parameter int unsigned CYC_CLKS = 4
)
(
    // clock and reset
    input wire logic               REF_CLK_I,
    input wire logic               RST_N_I,
    // instruction side
    input wire logic               INS_VALID_I,
    input wire ccd_pkg::ccd_ins_s  INS_I,
    input wire logic               INS_READY_O,
    input wire logic [14:0]        PC_O,
    // strobes
    input wire ccd_pkg::ccd_fwr_s  FILE_WR_O,
    input wire ccd_pkg::ccd_push_s STACK_O,
    input wire logic               WDT_CLR_O,
    input wire logic               WDT_PRE_CLR_O
);
    // =========================================================
    // helpers
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    logic take;
    // a word is consumed only when both sides agree
    assign take = INS_VALID_I && INS_READY_O;

    // six clocks hold at CYC_CLKS of 4: push clock through two clocks past the dead tick
    sequence s_dead_ticks;
        (!INS_READY_O)[*6];
    endsequence

    // =========================================================
    // properties
    a_call_two_cyc: assert property (STACK_O.push |-> s_dead_ticks)
        else $error("call did not idle one tick");
    a_push_ret_addr: assert property (STACK_O.push |->
        STACK_O.addr == 15'($past(PC_O) + 15'h1))
        else $error("return address not pc plus one");
    a_push_cause: assert property (STACK_O.push |-> $past(take) &&
        $past(INS_I.op) inside {ccd_pkg::OP_CALL_IMM, ccd_pkg::OP_CALL_ACC})
        else $error("push without call");
    a_imm_target: assert property (STACK_O.push &&
        $past(INS_I.op) == ccd_pkg::OP_CALL_IMM |->
        PC_O[10:0] == $past(INS_I.imm))
        else $error("immediate target wrong");
    a_kick_pair: assert property (WDT_CLR_O |-> WDT_PRE_CLR_O ##1
        !WDT_CLR_O && !WDT_PRE_CLR_O)
        else $error("prescaler clear not paired");
    a_kick_cause: assert property (WDT_CLR_O |-> $past(take) &&
        $past(INS_I.op) == ccd_pkg::OP_KICK)
        else $error("watchdog clear without kick");
    a_zero_write: assert property (FILE_WR_O.we &&
        $past(INS_I.op) == ccd_pkg::OP_ZERO_F |-> FILE_WR_O.data == 8'h00)
        else $error("zero file wrote nonzero");
    a_invert_write: assert property (FILE_WR_O.we &&
        $past(INS_I.op) == ccd_pkg::OP_INVERT |-> $past(INS_I.dest) &&
        FILE_WR_O.data == ~$past(INS_I.fval) &&
        FILE_WR_O.addr == $past(INS_I.freg))
        else $error("complement write wrong");
    a_minus_write: assert property (FILE_WR_O.we &&
        $past(INS_I.op) inside {ccd_pkg::OP_MINUS1, ccd_pkg::OP_MINUS1_SZ}
        |-> FILE_WR_O.data == $past(INS_I.fval) - 8'h01)
        else $error("decrement write wrong");
    a_dest_acc: assert property ($past(take) && !$past(INS_I.dest) &&
        $past(INS_I.op) == ccd_pkg::OP_INVERT |-> !FILE_WR_O.we)
        else $error("accumulator result went to file");
endmodule

bind ccd_core ccd_core_asserts #(.CYC_CLKS(CYC_CLKS)) chk_u
(
    .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .INS_VALID_I(INS_VALID_I),
    .INS_I(INS_I), .INS_READY_O(INS_READY_O), .PC_O(PC_O),
    .FILE_WR_O(FILE_WR_O), .STACK_O(STACK_O), .WDT_CLR_O(WDT_CLR_O),
    .WDT_PRE_CLR_O(WDT_PRE_CLR_O)
);

// [verif/cpu_call_clear_decrement_ops_tb.sv]
/*
 * Self-checking bench for ccd_core: random instruction stream against a
 * reference model. Assumes the register map and timing of the package.
 */
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end

module cpu_call_clear_decrement_ops_tb;
    // =========================================================
    // signals
    logic               REF_CLK_I = 1'b0;
    logic               RST_N_I = 1'b0;
    logic               INS_VALID_I = 1'b0;
    ccd_pkg::ccd_ins_s  INS_I = '0;
    logic               INS_READY_O, WDT_CLR_O, WDT_PRE_CLR_O;
    logic [14:0]        PC_O;
    ccd_pkg::ccd_fwr_s  FILE_WR_O;
    ccd_pkg::ccd_push_s STACK_O;
    logic               S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
    logic               S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0;
    logic               S_AXI_RREADY = 1'b0;
    logic [7:0]         S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [31:0]        S_AXI_WDATA = 32'h0;
    logic [3:0]         S_AXI_WSTRB = 4'hF;
    logic               S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
    logic               S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0]         S_AXI_BRESP, S_AXI_RRESP, rsp;
    logic [31:0]        S_AXI_RDATA, rdat;
    int                 err_count = 0, n_compared = 0;
    int                 m_pc, m_acc, m_upl, m_z, m_exp, m_slp, m_skip;
    ccd_pkg::ccd_ins_s  ins;

    ccd_core #(.CYC_CLKS(4)) dut_u
    (
        .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .INS_VALID_I(INS_VALID_I),
        .INS_I(INS_I), .INS_READY_O(INS_READY_O), .PC_O(PC_O),
        .FILE_WR_O(FILE_WR_O), .STACK_O(STACK_O), .WDT_CLR_O(WDT_CLR_O),
        .WDT_PRE_CLR_O(WDT_PRE_CLR_O), .S_AXI_AWVALID(S_AXI_AWVALID),
        .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_AWADDR(S_AXI_AWADDR),
        .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
        .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
        .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
        .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID),
        .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
        .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
        .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP)
    );

    // 40 MHz clock
    initial
    begin
        forever #12.5 REF_CLK_I = ~REF_CLK_I;
    end

    // =========================================================
    // bus tasks: entered and left just after a rising edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        bit done;
        done = 0;
        S_AXI_AWADDR  <= a;
        S_AXI_WDATA   <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID  <= 1'b1;
        S_AXI_BREADY  <= 1'b1;
        while (!done)
        begin
            @(posedge REF_CLK_I);
            if (S_AXI_AWREADY === 1'b1)
                S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY === 1'b1)
                S_AXI_WVALID <= 1'b0;
            if (S_AXI_BVALID === 1'b1)
            begin
                r = S_AXI_BRESP;
                S_AXI_BREADY <= 1'b0;
                done = 1;
            end
        end
        @(posedge REF_CLK_I); // let the drop land before a new request
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        bit done;
        done = 0;
        S_AXI_ARADDR  <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY  <= 1'b1;
        while (!done)
        begin
            @(posedge REF_CLK_I);
            if (S_AXI_ARREADY === 1'b1)
                S_AXI_ARVALID <= 1'b0;
            if (S_AXI_RVALID === 1'b1)
            begin
                d = S_AXI_RDATA;
                r = S_AXI_RRESP;
                S_AXI_RREADY <= 1'b0;
                done = 1;
            end
        end
        @(posedge REF_CLK_I);
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        axi_rd(a, rdat, rsp);
        `CHK(rdat, e)
        `CHK(rsp, ccd_pkg::RESP_OKAY)
    endtask

    // =========================================================
    // one instruction: model first, then offer until taken, then compare
    task automatic exec(input ccd_pkg::ccd_ins_s w);
        int ep, pa, res, upd, push, kick, we, wd;
        pa = (m_pc + 1) & 32'h7FFF;
        ep = pa;
        res = (w.op == ccd_pkg::OP_INVERT) ? ~w.fval : w.fval - 1;
        res = res & 255;
        push = 0; kick = 0; we = 0; wd = 0;
        if (m_skip)
            m_skip = 0; // discarded word acts as a no-operation
        else
        begin
            upd = w.op inside {ccd_pkg::OP_INVERT, ccd_pkg::OP_MINUS1,
                               ccd_pkg::OP_MINUS1_SZ};
            push = w.op inside {ccd_pkg::OP_CALL_IMM, ccd_pkg::OP_CALL_ACC};
            kick = w.op == ccd_pkg::OP_KICK;
            we = (upd && w.dest) || w.op == ccd_pkg::OP_ZERO_F;
            wd = (w.op == ccd_pkg::OP_ZERO_F) ? 0 : res;
            if (upd && !w.dest) m_acc = res;
            if (w.op == ccd_pkg::OP_ZERO_ACC) m_acc = 0;
            if (w.op inside {ccd_pkg::OP_INVERT, ccd_pkg::OP_MINUS1})
                m_z = (res == 0);
            if (w.op inside {ccd_pkg::OP_ZERO_F, ccd_pkg::OP_ZERO_ACC})
                m_z = 1;
            if (kick) m_exp = 1;
            if (kick) m_slp = 1;
            if (w.op == ccd_pkg::OP_MINUS1_SZ) m_skip = (res == 0);
            if (w.op == ccd_pkg::OP_CALL_IMM) ep = (m_upl >> 3) << 11 | w.imm;
            if (w.op == ccd_pkg::OP_CALL_ACC) ep = m_upl << 8 | m_acc;
        end
        m_pc = ep;
        INS_I <= w;
        INS_VALID_I <= 1'b1;
        do
            @(negedge REF_CLK_I);
        while (INS_READY_O !== 1'b1);
        @(posedge REF_CLK_I);
        INS_VALID_I <= 1'b0;
        @(negedge REF_CLK_I);
        `CHK(PC_O, 15'(m_pc))
        `CHK(STACK_O.push, 1'(push))
        if (push) `CHK(STACK_O.addr, 15'(pa))
        `CHK(FILE_WR_O.we, 1'(we))
        if (we) `CHK(FILE_WR_O, {1'b1, w.freg, 8'(wd)})
        `CHK({WDT_CLR_O, WDT_PRE_CLR_O}, {2{1'(kick)}})
        @(posedge REF_CLK_I);
        chk_reg(ccd_pkg::ADDR_ACC, 32'(m_acc));
        chk_reg(ccd_pkg::ADDR_STATUS, 32'({m_slp[0], m_exp[0], m_z[0]}));
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // =========================================================
    // main sequence
    initial
    begin
        int st, r;
        void'($urandom(32'h5cbd));
        repeat (6) @(posedge REF_CLK_I);
        RST_N_I <= 1'b1;
        @(posedge REF_CLK_I);
        chk_reg(ccd_pkg::ADDR_CTRL, 32'h0);
        chk_reg(ccd_pkg::ADDR_UPLAT, 32'h0);
        chk_reg(ccd_pkg::ADDR_ACC, 32'h0);
        chk_reg(ccd_pkg::ADDR_STATUS, 32'h6);
        chk_reg(ccd_pkg::ADDR_PC, 32'h0);
        axi_rd(8'h14, rdat, rsp);
        `CHK({rsp, rdat}, {ccd_pkg::RESP_SLVERR, 32'h0})
        axi_wr(8'h18, 32'hFF, rsp);
        `CHK(rsp, ccd_pkg::RESP_SLVERR)
        m_pc = 0; m_acc = 0; m_upl = 0; m_z = 0;
        m_exp = 1; m_slp = 1; m_skip = 0;
        axi_wr(ccd_pkg::ADDR_CTRL, 32'h1, rsp);
        for (int i = 0; i < 150; i++)
        begin
            if (i % 3 == 0)
            begin
                m_upl = $urandom & 127;
                m_acc = $urandom & 255;
                st = $urandom & 7;
                m_z = st & 1; m_exp = st >> 1 & 1; m_slp = st >> 2;
                axi_wr(ccd_pkg::ADDR_UPLAT, 32'(m_upl), rsp);
                axi_wr(ccd_pkg::ADDR_ACC, 32'(m_acc), rsp);
                axi_wr(ccd_pkg::ADDR_STATUS, 32'(st), rsp);
            end
            ins.op = ccd_pkg::ccd_op_e'(4'(i < 9 ? i : $urandom % 9));
            ins.imm = 11'($urandom);
            ins.freg = 7'($urandom);
            ins.dest = 1'($urandom);
            r = $urandom % 4; // bias towards results of zero
            ins.fval = r == 0 ? 8'h01 : r == 1 ? 8'hFF : 8'($urandom);
            exec(ins);
        end
        conclude();
    end

    // hang guard: the run needs well under a tenth of this
    initial
    begin
        #2ms;
        err_count++;
        conclude();
    end
endmodule
